// ===== logic/iplma_defs.vh
// constants of the interrupt priority and macro service arbiter
`ifndef IPLMA_DEFS_VH
`define IPLMA_DEFS_VH

// register byte offsets
`define IPLMA_OFS_CTRL      12'h000
`define IPLMA_OFS_STAT      12'h004
`define IPLMA_OFS_REQ       12'h008
`define IPLMA_OFS_MASK      12'h00c
`define IPLMA_OFS_MSEN      12'h010
`define IPLMA_OFS_PRIO_LO   12'h014
`define IPLMA_OFS_PRIO_HI   12'h018
`define IPLMA_OFS_MCNT      12'h01c
`define IPLMA_OFS_LAST      12'h020
`define IPLMA_OFS_PICK      12'h024

// field positions
`define IPLMA_CTRL_GIE      0
`define IPLMA_CTRL_NSEL     1
`define IPLMA_STAT_NMI      4
`define IPLMA_MCNT_IDX_LSB  8
`define IPLMA_LAST_LVL_LSB  8
`define IPLMA_LAST_MACRO    12
`define IPLMA_LAST_VALID    13
`define IPLMA_PICK_LVL_LSB  8
`define IPLMA_PICK_MACRO    12
`define IPLMA_PICK_VEC      13

// levels and admit masks, bit n set admits level n
`define IPLMA_N_LVL         4
`define IPLMA_LVL_W         2
`define IPLMA_ADMIT_NONE    4'h0
`define IPLMA_ADMIT_L0      4'h1
`define IPLMA_ADMIT_L01     4'h3
`define IPLMA_ADMIT_L012    4'h7
`define IPLMA_ADMIT_ALL     4'hf

// reset values
`define IPLMA_MASK_RST_BIT  1'b1
`define IPLMA_PRIO_RST_BIT  1'b1
`define IPLMA_ISR_RST       4'h0

`endif

// ===== logic/iplma_pick.v
// fixed default order picker: lowest index wins
module iplma_pick #(
  parameter W  = 23,
  parameter IW = 5
) (
  // candidates
  input  wire [W-1:0]  cand,
  // result
  output reg           any,
  output reg  [IW-1:0] idx
);

  integer i;

  always @* begin
    any = 1'b0;
    idx = {IW{1'b0}};
    // scanning downward lets the lowest index overwrite last
    for (i = W - 1; i >= 0; i = i - 1) begin
      if (cand[i]) begin
        any = 1'b1;
        idx = i[IW-1:0];
      end
    end
  end

endmodule

// ===== logic/iplma_isr.v
// in-service level record and admit mask for vectored requests
`include "iplma_defs.vh"
module iplma_isr (
  // clock and reset
  input  wire       clk_sys,
  input  wire       arst_n,
  // events
  input  wire       set_en,
  input  wire [1:0] set_lvl,
  input  wire       ret_clr,
  // admit conditions
  input  wire       gie,
  input  wire       nsel,
  input  wire       nmi_busy,
  // state
  output reg  [3:0] in_service_level_register,
  output reg  [3:0] allow
);

  wire [3:0] isr_inc  = ~in_service_level_register + `IPLMA_ADMIT_L0;
  wire [3:0] top_bit  = in_service_level_register & isr_inc;
  wire [3:0] clr_mask = ret_clr ? top_bit : `IPLMA_ADMIT_NONE;
  wire [3:0] set_mask = set_en ? (`IPLMA_ADMIT_L0 << set_lvl) : `IPLMA_ADMIT_NONE;

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      in_service_level_register <= `IPLMA_ISR_RST;
    end else begin
      // a nested entry in the same cycle as a return keeps its bit
      in_service_level_register <= (in_service_level_register & ~clr_mask) | set_mask; // RULE18 RULE19
    end
  end

  always @* begin
    allow = `IPLMA_ADMIT_NONE;
    if (gie && !nmi_busy && !in_service_level_register[0]) begin // RULE4
      if (in_service_level_register[1]) begin
        allow = `IPLMA_ADMIT_L0; // RULE5
      end else if (in_service_level_register[2]) begin
        allow = `IPLMA_ADMIT_L01; // RULE5
      end else if (in_service_level_register[3]) begin
        allow = nsel ? `IPLMA_ADMIT_L012 : `IPLMA_ADMIT_ALL; // RULE6
      end else begin
        allow = `IPLMA_ADMIT_ALL;
      end
    end
  end

endmodule

// ===== logic/iplma_top.v
// interrupt priority and macro service arbiter with apb registers
//
// Notes on behaviour
// RULE1 - four programmable levels, zero is highest
// RULE2 - fixed default order breaks remaining ties
// RULE3 - vectored acknowledge clears global enable flag
// RULE4 - enable off or level0/nmi: macro only
// RULE5 - accept only strictly higher level than served
// RULE6 - level3 served: select bit limits to 0..2
// RULE7 - macro ignores enable flag and levels
// RULE8 - hold lower level, take later higher first
// RULE9 - requests during disabled service stay pending
// RULE10 - pending requests taken by priority, not age
// RULE11 - macro requests beat vectored requests
// RULE12 - macro requests ordered by default order only
// RULE13 - vectored taken from highest level down
// RULE14 - same level: higher default order first
// RULE15 - macro acknowledge starts transfer, not vector
// RULE16 - vectored raised after programmed macro count
// RULE17 - candidate only when flag set, unmasked
// RULE18 - vectored acknowledge sets in-service level bit
// RULE19 - return clears highest set in-service bit
`include "iplma_defs.vh"
module iplma_top #(
  parameter N_SRC = 23,
  parameter IW    = 5,
  parameter CNT_W = 8
) (
  // clock and reset
  input  wire              clk_sys,
  input  wire              arst_n,
  // apb slave
  input  wire [11:0]       paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  // peripheral requests, one-cycle pulses
  input  wire [N_SRC-1:0]  irq_set,
  // cpu core
  input  wire              core_ready,
  input  wire              reti,
  input  wire              nmi_busy,
  input  wire              enable_irq_instr,
  input  wire              disable_irq_instr,
  output reg               vec_ack,
  output reg               xfer_start,
  output reg  [IW-1:0]     ack_src,
  output reg  [1:0]        ack_lvl,
  output wire              global_irq_enable
);

  localparam [CNT_W-1:0] CNT_ONE = {{(CNT_W-1){1'b0}}, 1'b1};
  localparam [N_SRC-1:0] SRC_ONE = {{(N_SRC-1){1'b0}}, 1'b1};

  reg  [N_SRC-1:0] req_flag;
  reg  [N_SRC-1:0] mask_flag;
  reg  [N_SRC-1:0] msen;
  reg  [N_SRC-1:0] prio_lo;
  reg  [N_SRC-1:0] prio_hi;
  reg  [CNT_W-1:0] mcount [0:N_SRC-1];
  reg              global_irq_enable_flag;
  reg              level3_nesting_select;
  reg  [IW-1:0]    mcnt_sel;
  reg  [IW-1:0]    last_src;
  reg  [1:0]       last_lvl;
  reg              last_macro;
  reg              last_valid;

  wire [3:0]       in_service_level_register;
  wire [3:0]       allow;

  assign global_irq_enable = global_irq_enable_flag;

  // apb decode; zero wait states, every access completes at once
  wire setup_ph = psel & ~penable;
  wire acc_ph   = psel & penable;
  wire hit_ctrl = (paddr == `IPLMA_OFS_CTRL);
  wire hit_stat = (paddr == `IPLMA_OFS_STAT);
  wire hit_req  = (paddr == `IPLMA_OFS_REQ);
  wire hit_mask = (paddr == `IPLMA_OFS_MASK);
  wire hit_msen = (paddr == `IPLMA_OFS_MSEN);
  wire hit_plo  = (paddr == `IPLMA_OFS_PRIO_LO);
  wire hit_phi  = (paddr == `IPLMA_OFS_PRIO_HI);
  wire hit_mcnt = (paddr == `IPLMA_OFS_MCNT);
  wire hit_last = (paddr == `IPLMA_OFS_LAST);
  wire hit_pick = (paddr == `IPLMA_OFS_PICK);
  wire hit_any  = hit_ctrl | hit_stat | hit_req | hit_mask | hit_msen | hit_plo | hit_phi | hit_mcnt |
                  hit_last | hit_pick;

  assign pready  = 1'b1;
  assign pslverr = acc_ph & ~hit_any;

  wire wr_en   = acc_ph & pwrite;
  wire wr_ctrl = wr_en & hit_ctrl;
  wire wr_req  = wr_en & hit_req;
  wire wr_mask = wr_en & hit_mask;
  wire wr_msen = wr_en & hit_msen;
  wire wr_plo  = wr_en & hit_plo;
  wire wr_phi  = wr_en & hit_phi;
  wire wr_mcnt = wr_en & hit_mcnt;

  wire [IW-1:0]    wr_idx  = pwdata[`IPLMA_MCNT_IDX_LSB +: IW];
  wire [N_SRC-1:0] wdata_n = pwdata[N_SRC-1:0];

  // candidates
  wire [N_SRC-1:0] live  = req_flag & ~mask_flag; // RULE17
  wire [N_SRC-1:0] mcand = live & msen;
  wire [N_SRC-1:0] vcand = live & ~msen;

  // split vectored candidates by programmable level
  wire [`IPLMA_N_LVL*N_SRC-1:0] lvl_cand;
  wire [`IPLMA_N_LVL-1:0]       lvl_any;
  wire [`IPLMA_N_LVL*IW-1:0]    lvl_idx;

  genvar gl;
  genvar gs;
  generate
    for (gl = 0; gl < `IPLMA_N_LVL; gl = gl + 1) begin : g_lvl
      for (gs = 0; gs < N_SRC; gs = gs + 1) begin : g_src
        assign lvl_cand[gl*N_SRC+gs] = vcand[gs] & ({prio_hi[gs], prio_lo[gs]} == gl); // RULE1
      end
      iplma_pick #(
        .W  (N_SRC),
        .IW (IW)
      ) u_lvl_pick (
        .cand (lvl_cand[gl*N_SRC +: N_SRC]),
        .any  (lvl_any[gl]),
        .idx  (lvl_idx[gl*IW +: IW])
      ); // RULE2 RULE14
    end
  endgenerate

  wire          m_any;
  wire [IW-1:0] m_idx;

  // macro order ignores programmable levels entirely
  iplma_pick #(
    .W  (N_SRC),
    .IW (IW)
  ) u_macro_pick (
    .cand (mcand),
    .any  (m_any),
    .idx  (m_idx)
  ); // RULE12

  // best admitted level; lowest level number scanned last wins
  reg          v_ok;
  reg [IW-1:0] v_idx;
  reg [1:0]    v_lvl;
  integer      li;

  always @* begin
    v_ok  = 1'b0;
    v_idx = {IW{1'b0}};
    v_lvl = 2'h0;
    for (li = `IPLMA_N_LVL - 1; li >= 0; li = li - 1) begin
      if (lvl_any[li] && allow[li]) begin // RULE8 RULE10
        v_ok  = 1'b1;
        v_idx = lvl_idx[li*IW +: IW];
        v_lvl = li[1:0];
      end
    end // RULE13
  end

  // macro first whenever both kinds are present
  wire do_macro = core_ready & m_any; // RULE7 RULE11
  wire do_vec   = core_ready & ~m_any & v_ok;

  // final macro operation leaves the flag set so it turns vectored
  wire [CNT_W-1:0] m_cnt   = mcount[m_idx];
  wire             m_final = do_macro & (m_cnt <= CNT_ONE);
  wire [N_SRC-1:0] m_bit   = SRC_ONE << m_idx;
  wire [N_SRC-1:0] v_bit   = SRC_ONE << v_idx;
  wire [N_SRC-1:0] ack_clr = (do_macro & ~m_final) ? m_bit : (do_vec ? v_bit : {N_SRC{1'b0}});
  wire [N_SRC-1:0] fin_clr = m_final ? m_bit : {N_SRC{1'b0}};
  wire [N_SRC-1:0] sw_clr  = wr_req ? wdata_n : {N_SRC{1'b0}};

  // in-service record
  iplma_isr u_isr (
    .clk_sys                   (clk_sys),
    .arst_n                    (arst_n),
    .set_en                    (do_vec),
    .set_lvl                   (v_lvl),
    .ret_clr                   (reti),
    .gie                       (global_irq_enable_flag),
    .nsel                      (level3_nesting_select),
    .nmi_busy                  (nmi_busy),
    .in_service_level_register (in_service_level_register),
    .allow                     (allow)
  );

  // flags and configuration
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      req_flag               <= {N_SRC{1'b0}};
      mask_flag              <= {N_SRC{`IPLMA_MASK_RST_BIT}};
      msen                   <= {N_SRC{1'b0}};
      prio_lo                <= {N_SRC{`IPLMA_PRIO_RST_BIT}};
      prio_hi                <= {N_SRC{`IPLMA_PRIO_RST_BIT}};
      global_irq_enable_flag <= 1'b0;
      level3_nesting_select  <= 1'b0;
      mcnt_sel               <= {IW{1'b0}};
    end else begin
      // a new pulse wins over an acknowledge or software clear
      req_flag <= (req_flag & ~ack_clr & ~sw_clr) | irq_set; // RULE9
      msen     <= (wr_msen ? wdata_n : msen) & ~fin_clr; // RULE16
      if (wr_mask) begin
        mask_flag <= wdata_n;
      end
      if (wr_plo) begin
        prio_lo <= wdata_n;
      end
      if (wr_phi) begin
        prio_hi <= wdata_n;
      end
      if (wr_ctrl) begin
        level3_nesting_select <= pwdata[`IPLMA_CTRL_NSEL];
      end
      if (wr_mcnt) begin
        mcnt_sel <= wr_idx;
      end
      // acknowledge beats any enabling in the same cycle
      if (do_vec) begin
        global_irq_enable_flag <= 1'b0; // RULE3
      end else if (disable_irq_instr) begin
        global_irq_enable_flag <= 1'b0;
      end else if (enable_irq_instr) begin
        global_irq_enable_flag <= 1'b1;
      end else if (wr_ctrl) begin
        global_irq_enable_flag <= pwdata[`IPLMA_CTRL_GIE];
      end
    end
  end

  // macro operation counters, one per source
  generate
    for (gs = 0; gs < N_SRC; gs = gs + 1) begin : g_cnt
      always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          mcount[gs] <= {CNT_W{1'b0}};
        end else if (wr_mcnt && (wr_idx == gs)) begin
          mcount[gs] <= pwdata[CNT_W-1:0];
        end else if (do_macro && (m_idx == gs) && (mcount[gs] != {CNT_W{1'b0}})) begin
          mcount[gs] <= mcount[gs] - CNT_ONE; // RULE16
        end
      end
    end
  endgenerate

  // acknowledge outputs, one-cycle pulses with held source and level
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      vec_ack    <= 1'b0;
      xfer_start <= 1'b0;
      ack_src    <= {IW{1'b0}};
      ack_lvl    <= 2'h0;
      last_src   <= {IW{1'b0}};
      last_lvl   <= 2'h0;
      last_macro <= 1'b0;
      last_valid <= 1'b0;
    end else begin
      vec_ack    <= do_vec;
      xfer_start <= do_macro; // RULE15
      if (do_macro) begin
        ack_src    <= m_idx;
        ack_lvl    <= {prio_hi[m_idx], prio_lo[m_idx]};
        last_src   <= m_idx;
        last_lvl   <= {prio_hi[m_idx], prio_lo[m_idx]};
        last_macro <= 1'b1;
        last_valid <= 1'b1;
      end else if (do_vec) begin
        ack_src    <= v_idx;
        ack_lvl    <= v_lvl;
        last_src   <= v_idx;
        last_lvl   <= v_lvl;
        last_macro <= 1'b0;
        last_valid <= 1'b1;
      end
    end
  end

  // read mux; data is a snapshot taken at the setup edge
  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_prdata[`IPLMA_CTRL_GIE]  = global_irq_enable_flag;
      next_prdata[`IPLMA_CTRL_NSEL] = level3_nesting_select;
    end else if (hit_stat) begin
      next_prdata[3:0]             = in_service_level_register;
      next_prdata[`IPLMA_STAT_NMI] = nmi_busy;
    end else if (hit_req) begin
      next_prdata[N_SRC-1:0] = req_flag;
    end else if (hit_mask) begin
      next_prdata[N_SRC-1:0] = mask_flag;
    end else if (hit_msen) begin
      next_prdata[N_SRC-1:0] = msen;
    end else if (hit_plo) begin
      next_prdata[N_SRC-1:0] = prio_lo;
    end else if (hit_phi) begin
      next_prdata[N_SRC-1:0] = prio_hi;
    end else if (hit_mcnt) begin
      next_prdata[CNT_W-1:0]                    = mcount[mcnt_sel];
      next_prdata[`IPLMA_MCNT_IDX_LSB +: IW]    = mcnt_sel;
    end else if (hit_last) begin
      next_prdata[IW-1:0]                       = last_src;
      next_prdata[`IPLMA_LAST_LVL_LSB +: 2]     = last_lvl;
      next_prdata[`IPLMA_LAST_MACRO]            = last_macro;
      next_prdata[`IPLMA_LAST_VALID]            = last_valid;
    end else if (hit_pick) begin
      next_prdata[IW-1:0]                       = m_any ? m_idx : v_idx;
      next_prdata[`IPLMA_PICK_LVL_LSB +: 2]     = m_any ? {prio_hi[m_idx], prio_lo[m_idx]} : v_lvl;
      next_prdata[`IPLMA_PICK_MACRO]            = m_any;
      next_prdata[`IPLMA_PICK_VEC]              = v_ok;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
    end else if (setup_ph && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule

// ===== testbench/iplma_properties.sv
// assertion checker on the arbiter's core-side ports
module iplma_properties #(
  parameter N_SRC = 23,
  parameter IW    = 5
) (
  // clock and reset
  input wire logic          clk_sys,
  input wire logic          arst_n,
  // core side
  input wire logic          core_ready,
  input wire logic          nmi_busy,
  input wire logic          enable_irq_instr,
  input wire logic          disable_irq_instr,
  input wire logic          vec_ack,
  input wire logic          xfer_start,
  input wire logic [IW-1:0] ack_src,
  input wire logic [1:0]    ack_lvl,
  input wire logic          global_irq_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_ack;
    vec_ack || xfer_start;
  endsequence
  // without a ready core no acknowledge can clear the flag in between
  sequence s_ei_only;
    enable_irq_instr && !disable_irq_instr && !core_ready;
  endsequence

  chk_ack_exclusive: assert property (!(vec_ack && xfer_start))
    else $error("vectored and macro acknowledge together");
  chk_vec_clears_ie: assert property (vec_ack |-> !global_irq_enable)
    else $error("global enable still set after vectored acknowledge");
  chk_vec_entry: assert property (vec_ack |-> $past(global_irq_enable) && !$past(nmi_busy))
    else $error("vectored acknowledge while blocked");
  chk_ack_needs_ready: assert property (s_ack |-> $past(core_ready))
    else $error("acknowledge without ready core");
  chk_vec_single: assert property (vec_ack |=> !vec_ack)
    else $error("two vectored acknowledges back to back");
  chk_ei_sets_ie: assert property (s_ei_only |=> global_irq_enable)
    else $error("enable pulse did not set global enable");
  chk_di_clears_ie: assert property (disable_irq_instr |=> !global_irq_enable)
    else $error("disable pulse did not clear global enable");
  chk_ack_hold: assert property (!vec_ack && !xfer_start |-> $stable(ack_src) && $stable(ack_lvl))
    else $error("acknowledge source changed without acknowledge");
  chk_src_range: assert property (s_ack |-> ack_src < N_SRC)
    else $error("acknowledge source out of range");
endmodule

// ===== testbench/iplma_core_model.sv
// behavioural cpu core: offers one acknowledge slot on request
module iplma_core_model #(
  parameter IW = 5
) (
  // clock
  input wire logic           clk_sys,
  // bench control
  input wire logic           want,
  input wire logic [1:0]     dly,
  output logic               done,
  output logic [IW+3:0]      got,
  // arbiter side
  output logic               core_ready,
  input wire logic           vec_ack,
  input wire logic           xfer_start,
  input wire logic [IW-1:0]  ack_src,
  input wire logic [1:0]     ack_lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    core_ready = 0;
    done = 0;
    got = 0;
    forever begin
      @(posedge clk_sys);
      if (want) begin
        // random delay gives both prompt and slow cores
        repeat (dly) @(posedge clk_sys);
        core_ready <= 1;
        @(posedge clk_sys);
        core_ready <= 0;
        @(posedge clk_sys);
        got <= {xfer_start, vec_ack, ack_lvl, ack_src};
        done <= 1;
        @(posedge clk_sys);
        done <= 0;
      end
    end
  end
endmodule

// ===== testbench/tb_top.sv
// random self-checking bench for the interrupt arbiter
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam N = 23;
  logic         clk_sys = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = 0;
  logic [31:0]  pwdata = 0, prdata, rd, v;
  logic         pready, pslverr, err, core_ready, vec_ack, xfer_start, global_irq_enable, done;
  logic [N-1:0] irq_set = 0, flg = 0, msk = '1, ms = 0, lo = '1, hi = '1;
  logic         reti = 0, nmi_busy = 0, enable_irq_instr = 0, disable_irq_instr = 0, want = 0;
  logic [4:0]   ack_src;
  logic [1:0]   ack_lvl, dly = 0;
  logic [8:0]   got;
  int           err_count = 0, total_checks = 0, cnt[N], isr = 0, gie = 0, nsel = 0, nmi = 0, last = 0, k;
  int           lastr = 0;
  logic [11:0]  ra[8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h040};
  logic [31:0]  rv[8] = '{0, 0, 0, 32'h007f_ffff, 0, 32'h007f_ffff, 32'h007f_ffff, 0};

  iplma_top uut (.clk_sys(clk_sys), .arst_n(arst_n), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq_set(irq_set), .core_ready(core_ready), .reti(reti), .nmi_busy(nmi_busy),
    .enable_irq_instr(enable_irq_instr), .disable_irq_instr(disable_irq_instr), .vec_ack(vec_ack),
    .xfer_start(xfer_start), .ack_src(ack_src), .ack_lvl(ack_lvl), .global_irq_enable(global_irq_enable));
  iplma_core_model u_core (.clk_sys(clk_sys), .want(want), .dly(dly), .done(done), .got(got),
    .core_ready(core_ready), .vec_ack(vec_ack), .xfer_start(xfer_start), .ack_src(ack_src), .ack_lvl(ack_lvl));

  always #5 clk_sys = ~clk_sys;

  task summarize();
    if (err_count == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  function automatic int pick();
    int a;
    a = 15;
    if (isr[3]) a = nsel ? 7 : 15;
    if (isr[2]) a = 3;
    if (isr[1]) a = 1;
    if (!gie || nmi || isr[0]) a = 0;
    for (int i = 0; i < N; i++)
      if (flg[i] && !msk[i] && ms[i]) return 64 + i;
    for (int l = 0; l < 4; l++)
      for (int i = 0; i < N; i++)
        if (a[l] && flg[i] && !msk[i] && !ms[i] && 2 * hi[i] + lo[i] == l) return i;
    return -1;
  endfunction

  task take();
    int p, q, e, n, lv;
    p = pick();
    q = p < 0 ? 0 : p % 64;
    lv = p < 0 ? 0 : 2 * hi[q] + lo[q];
    // winner preview; vectored admissibility is not modelled while a macro request is pending
    e = p < 0 ? 0 : (p >= 64 ? 4096 : 8192) + lv * 256 + q;
    apb(0, 12'h024, 0);
    check(rd & (p >= 64 ? 32'hffff_dfff : 32'hffff_ffff), e);
    e = 0;
    dly <= $urandom_range(0, 3);
    want <= 1;
    @(posedge clk_sys);
    want <= 0;
    n = 0;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk_sys);
      n++;
    end
    if (p >= 0) begin
      last = lv * 32 + q;
      lastr = 8192 + (p >= 64 ? 4096 : 0) + lv * 256 + q;
      e = p >= 64 ? 256 : 128;
      if (p >= 64 && cnt[q] <= 1) begin
        ms[q] = 0;
        cnt[q] = 0;
      end else if (p >= 64) begin
        flg[q] = 0;
        cnt[q]--;
      end else begin
        flg[q] = 0;
        gie = 0;
        isr[lv] = 1;
      end
    end
    check(got, e | last);
    check(global_irq_enable, gie);
    apb(0, 12'h008, 0);
    check(rd, flg);
    apb(0, 12'h004, 0);
    check(rd, {nmi, isr[3:0]});
    apb(0, 12'h020, 0);
    check(rd, lastr);
  endtask

  initial begin
    #400_000;
    err_count++;
    summarize();
  end

  initial begin
    rd = $urandom(32'h0000_4b12);
    foreach (cnt[i]) cnt[i] = 0;
    repeat (10) @(posedge clk_sys);
    arst_n <= 1;
    foreach (ra[i]) begin
      apb(0, ra[i], 0);
      check(rd, rv[i]);
    end
    apb(1, 12'h040, 32'hffff_ffff);
    check(err, 1);
    repeat (400) begin
      case ($urandom_range(0, 7))
        0: begin
          v = $urandom & $urandom & $urandom;
          @(posedge clk_sys);
          irq_set <= v[N-1:0];
          flg |= v[N-1:0];
          @(posedge clk_sys);
          irq_set <= 0;
        end
        1: begin
          v = $urandom & $urandom;
          apb(1, 12'h00c, v);
          msk = v[N-1:0];
          // write one to clear pending flags
          v = $urandom & $urandom;
          apb(1, 12'h008, v);
          flg &= ~v[N-1:0];
        end
        2: begin
          v = $urandom & $urandom & $urandom;
          // exhausted counters stay out: a zero count ends macro service at the first transfer
          foreach (cnt[i]) if (cnt[i] == 0) v[i] = 0;
          apb(1, 12'h010, v);
          ms = v[N-1:0];
        end
        3: begin
          v = $urandom;
          apb(1, 12'h014, v);
          lo = v[N-1:0];
          v = $urandom;
          apb(1, 12'h018, v);
          hi = v[N-1:0];
        end
        4: begin
          k = $urandom_range(0, N - 1);
          cnt[k] = $urandom_range(0, 3);
          apb(1, 12'h01c, k * 256 + cnt[k]);
          apb(0, 12'h01c, 0);
          check(rd, k * 256 + cnt[k]);
        end
        5: begin
          v = $urandom_range(0, 3);
          apb(1, 12'h000, v);
          gie = v[0];
          nsel = v[1];
        end
        6: begin
          k = $urandom_range(0, 2);
          @(posedge clk_sys);
          enable_irq_instr <= k == 0;
          disable_irq_instr <= k == 1;
          reti <= k == 2;
          @(posedge clk_sys);
          {enable_irq_instr, disable_irq_instr, reti} <= 0;
          if (k < 2) gie = k == 0;
          else isr &= isr - 1;
        end
        default: begin
          nmi = $urandom_range(0, 3) == 0;
          @(posedge clk_sys);
          nmi_busy <= nmi;
        end
      endcase
      take();
    end
    summarize();
  end
endmodule

bind iplma_top iplma_properties #(.N_SRC(N_SRC), .IW(IW)) u_chk (.clk_sys(clk_sys), .arst_n(arst_n),
  .core_ready(core_ready), .nmi_busy(nmi_busy), .enable_irq_instr(enable_irq_instr),
  .disable_irq_instr(disable_irq_instr), .vec_ack(vec_ack), .xfer_start(xfer_start), .ack_src(ack_src),
  .ack_lvl(ack_lvl), .global_irq_enable(global_irq_enable));
